/* File: core/clk_startup_regs.vh */
/*
 * Constants for the clock source and start-up delay block: register
 * offsets, field positions, reset values and start-up cycle counts.
 * Assumes it is included by bare name from the design files only.
 */
`ifndef CLK_STARTUP_REGS_VH
`define CLK_STARTUP_REGS_VH

// Register byte offsets
`define OFS_CTRL        4'h0
`define OFS_STATUS      4'h4
`define OFS_CONFIG      4'h8

// Control register bits (write one to request)
`define CTRL_DOWN_BIT   0
`define CTRL_NOISE_BIT  1

// Config register fields
`define CFG_KIND_LSB    0
`define CFG_RANGE_LSB   5
`define CFG_WAKE_LSB    7
`define CFG_REXT_LSB    10
`define CFG_FULL_BIT    12
`define CFG_CAP_BIT     13
`define CFG_SRC_LSB     16
`define CFG_SUT_LSB     20
`define CFG_SWING_BIT   22

// Source kinds, one-hot
`define KIND_XTAL       5'h01
`define KIND_LFXTAL     5'h02
`define KIND_EXTRC      5'h04
`define KIND_INTRC      5'h08
`define KIND_EXTCLK     5'h10

// Factory default fuse image
`define FUSE_SRC_RESET  4'h1
`define FUSE_SUT_RESET  2'h2
`define FUSE_SWING_RESET 1'h1

// Wake delay selectors
`define WAKE_6          3'h0
`define WAKE_18         3'h1
`define WAKE_258        3'h2
`define WAKE_1K         3'h3
`define WAKE_16K        3'h4
`define WAKE_32K        3'h5

// Reset extra selectors
`define REXT_NONE       2'h0
`define REXT_SHORT      2'h1
`define REXT_LONG       2'h2

// Start-up cycle counts
`define CYC_6           17'h00006
`define CYC_18          17'h00012
`define CYC_258         17'h00102
`define CYC_1K          17'h00400
`define CYC_16K         17'h04000
`define CYC_32K         17'h08000
`define WDT_SHORT_CYC   17'h01000
`define WDT_LONG_CYC    17'h10000

`endif

/* File: core/startup_counter.v */
/*
 * Tick counter for start-up delays: loads a cycle count on start and
 * pulses done after that many tick enables.
 * Assumes tick is a one-cycle enable synchronous to clk_sys.
 */
`timescale 1ns/1ps
module startup_counter (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_b,
	// Control
	input  wire        start,
	input  wire [16:0] limit,
	input  wire        tick,
	// Result
	output reg         done_r,
	output reg         busy_r
);
	reg [16:0] cnt_r;

	// Count ticks until the loaded limit is reached
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r  <= 17'h00000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (start) begin
				cnt_r  <= limit;
				busy_r <= 1'b1;
			end else if (busy_r && tick) begin
				cnt_r <= cnt_r - 17'h00001;
				if (cnt_r == 17'h00001) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end
endmodule // startup_counter

/* File: core/clock_source_startup_select.v */
/*
 * Clock source selection and start-up sequencing. Decodes the fuse
 * image, times the reset extension on the watchdog oscillator and the
 * stabilisation on the selected source, and gates the core clocks.
 * Assumes fuse inputs are stable at reset release, wdt_tick and
 * src_tick are one-cycle enables per oscillator cycle, and software
 * reaches the registers over Avalon-MM with waitrequest.
 */
`timescale 1ns/1ps
`include "clk_startup_regs.vh"
module clock_source_startup_select #(
	parameter [16:0] WDT_SHORT = `WDT_SHORT_CYC,
	parameter [16:0] WDT_LONG  = `WDT_LONG_CYC,
	parameter [16:0] SRC_16K   = `CYC_16K,
	parameter [16:0] SRC_32K   = `CYC_32K
) (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_b,
	// Fuse image
	input  wire [3:0]  source_select_fuses,
	input  wire [1:0]  startup_time_fuses,
	input  wire        swing_option_fuse,
	// Oscillator ticks and wake event
	input  wire        wdt_tick,
	input  wire        src_tick,
	input  wire        wake_req,
	// Avalon-MM slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Oscillator control
	output reg  [4:0]  source_kind_r,
	output reg  [1:0]  range_code_r,
	output reg         amp_full_swing_r,
	output reg         load_caps_on_r,
	output reg         osc_enable_r,
	// Clock gating and core hold
	output reg         cpu_reset_hold_r,
	output reg         cpu_clk_en_r,
	output reg         io_clk_en_r,
	output reg         converter_clk_en_r
);
	// Sequencer states, one-hot
	localparam [5:0] S_LOAD  = 6'h01;
	localparam [5:0] S_RSTX  = 6'h02;
	localparam [5:0] S_STAB  = 6'h04;
	localparam [5:0] S_RUN   = 6'h08;
	localparam [5:0] S_DOWN  = 6'h10;
	localparam [5:0] S_NOISE = 6'h20;

	reg  [5:0]  state_r;
	reg  [5:0]  state_nxt;
	reg  [3:0]  src_r;
	reg  [1:0]  sut_r;
	reg         swing_r;
	reg  [2:0]  wake_sel_r;
	reg  [1:0]  rext_sel_r;
	reg         boot_r;
	reg         cnt_start_r;
	reg  [16:0] cnt_limit_r;
	wire        cnt_done;
	wire        cnt_busy;
	wire        cnt_tick;
	wire        req;
	wire        take;
	wire [4:0]  kind_dec;
	wire [2:0]  wake_dec;
	wire [1:0]  rext_dec;
	wire        swing_prog;

	// Source kind from the four select bits
	function [4:0] kind_of;
		input [3:0] s;
		begin
			if (s >= 4'hA)
				kind_of = `KIND_XTAL;
			else if (s == 4'h9)
				kind_of = `KIND_LFXTAL;
			else if (s >= 4'h5)
				kind_of = `KIND_EXTRC;
			else if (s >= 4'h1)
				kind_of = `KIND_INTRC;
			else
				kind_of = `KIND_EXTCLK;
		end
	endfunction

	// Wake delay selector for source and start-up code
	function [2:0] wake_of;
		input [3:0] s;
		input [1:0] t;
		reg   [4:0] k;
		begin
			k = kind_of(s);
			wake_of = `WAKE_6;
			case (k)
			`KIND_XTAL: begin
				case ({s[0], t})
				3'h0, 3'h1: wake_of = `WAKE_258;
				3'h2, 3'h3, 3'h4: wake_of = `WAKE_1K;
				default: wake_of = `WAKE_16K;
				endcase
			end
			`KIND_LFXTAL: begin
				wake_of = (t[1]) ? `WAKE_32K : `WAKE_1K;
			end
			`KIND_EXTRC: begin
				wake_of = (t == 2'h3) ? `WAKE_6 : `WAKE_18;
			end
			default: begin
				wake_of = `WAKE_6;
			end
			endcase
		end
	endfunction

	// Reset extra selector for source and start-up code
	function [1:0] rext_of;
		input [3:0] s;
		input [1:0] t;
		reg   [4:0] k;
		begin
			k = kind_of(s);
			rext_of = `REXT_NONE;
			case (k)
			`KIND_XTAL: begin
				case ({s[0], t})
				3'h0, 3'h3, 3'h6: rext_of = `REXT_SHORT;
				3'h1, 3'h4, 3'h7: rext_of = `REXT_LONG;
				default: rext_of = `REXT_NONE;
				endcase
			end
			`KIND_LFXTAL: begin
				rext_of = (t == 2'h0) ? `REXT_SHORT : `REXT_LONG;
			end
			`KIND_EXTRC: begin
				case (t)
				2'h0: rext_of = `REXT_NONE;
				2'h2: rext_of = `REXT_LONG;
				default: rext_of = `REXT_SHORT;
				endcase
			end
			default: begin
				case (t)
				2'h0: rext_of = `REXT_NONE;
				2'h1: rext_of = `REXT_SHORT;
				default: rext_of = `REXT_LONG;
				endcase
			end
			endcase
		end
	endfunction

	// Cycle count for a wake selector
	function [16:0] wake_cycles;
		input [2:0] w;
		begin
			case (w)
			`WAKE_6:   wake_cycles = `CYC_6;
			`WAKE_18:  wake_cycles = `CYC_18;
			`WAKE_258: wake_cycles = `CYC_258;
			`WAKE_1K:  wake_cycles = `CYC_1K;
			`WAKE_16K: wake_cycles = SRC_16K;
			default:   wake_cycles = SRC_32K;
			endcase
		end
	endfunction

	// Decode straight from the fuse pins while loading
	assign kind_dec   = kind_of(source_select_fuses);
	assign wake_dec   = wake_of(source_select_fuses, startup_time_fuses);
	assign rext_dec   = rext_of(source_select_fuses, startup_time_fuses);
	assign swing_prog = ~swing_option_fuse;
	assign cnt_tick   = (state_r == S_RSTX) ? wdt_tick : src_tick;
	assign req        = avs_read | avs_write;
	assign take       = req & ~avs_waitrequest;

	startup_counter u_cnt (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.start   (cnt_start_r),
		.limit   (cnt_limit_r),
		.tick    (cnt_tick),
		.done_r  (cnt_done),
		.busy_r  (cnt_busy)
	);

	// Fuse capture at reset release, held until the next reset
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			src_r            <= `FUSE_SRC_RESET;
			sut_r            <= `FUSE_SUT_RESET;
			swing_r          <= `FUSE_SWING_RESET;
			source_kind_r    <= `KIND_INTRC;
			wake_sel_r       <= `WAKE_6;
			rext_sel_r       <= `REXT_LONG;
			range_code_r     <= 2'h0;
			amp_full_swing_r <= 1'b0;
			load_caps_on_r   <= 1'b0;
		end else if (state_r == S_LOAD) begin
			src_r            <= source_select_fuses;
			sut_r            <= startup_time_fuses;
			swing_r          <= swing_option_fuse;
			source_kind_r    <= kind_dec;
			wake_sel_r       <= wake_dec;
			rext_sel_r       <= rext_dec;
			amp_full_swing_r <= (kind_dec == `KIND_XTAL) & swing_prog;
			load_caps_on_r   <= swing_prog & (kind_dec != `KIND_XTAL)
				& (kind_dec != `KIND_INTRC);
			case (kind_dec)
			`KIND_XTAL:   range_code_r <= swing_prog ? 2'h3
				: source_select_fuses[2:1] - 2'h1;
			`KIND_EXTRC:  range_code_r <= source_select_fuses[1:0] - 2'h1;
			`KIND_INTRC:  range_code_r <= source_select_fuses[1:0] - 2'h1;
			default:      range_code_r <= 2'h0;
			endcase
		end
	end

	// Next state of the start-up sequencer
	always @* begin
		state_nxt = state_r;
		case (state_r)
		S_LOAD: begin
			state_nxt = (rext_dec == `REXT_NONE) ? S_STAB : S_RSTX;
		end
		S_RSTX: begin
			if (cnt_done)
				state_nxt = S_STAB;
		end
		S_STAB: begin
			if (cnt_done)
				state_nxt = S_RUN;
		end
		S_RUN: begin
			if (take && avs_write && avs_address == `OFS_CTRL) begin
				if (avs_writedata[`CTRL_DOWN_BIT])
					state_nxt = S_DOWN;
				else if (avs_writedata[`CTRL_NOISE_BIT])
					state_nxt = S_NOISE;
			end
		end
		S_DOWN: begin
			if (wake_req)
				state_nxt = S_STAB;
		end
		S_NOISE: begin
			if (wake_req)
				state_nxt = S_RUN;
		end
		default: begin
			state_nxt = S_LOAD;
		end
		endcase
	end

	// Sequencer, counter loading and clock gating
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r            <= S_LOAD;
			boot_r             <= 1'b1;
			cnt_start_r        <= 1'b0;
			cnt_limit_r        <= 17'h00000;
			cpu_reset_hold_r   <= 1'b1;
			cpu_clk_en_r       <= 1'b0;
			io_clk_en_r        <= 1'b0;
			converter_clk_en_r <= 1'b0;
			osc_enable_r       <= 1'b1;
		end else begin
			state_r     <= state_nxt;
			cnt_start_r <= 1'b0;
			if (state_r == S_LOAD) begin
				cnt_start_r <= 1'b1;
				if (rext_dec == `REXT_NONE)
					cnt_limit_r <= wake_cycles(wake_dec);
				else
					cnt_limit_r <= (rext_dec == `REXT_LONG) ? WDT_LONG : WDT_SHORT;
			end else if ((state_r == S_RSTX && cnt_done)
				|| (state_r == S_DOWN && wake_req)) begin
				cnt_start_r <= 1'b1;
				cnt_limit_r <= wake_cycles(wake_sel_r);
			end
			if (state_nxt == S_RUN)
				boot_r <= 1'b0;
			// Core held at boot until the last start-up count ends
			cpu_reset_hold_r   <= boot_r & (state_nxt != S_RUN);
			cpu_clk_en_r       <= (state_nxt == S_RUN);
			io_clk_en_r        <= (state_nxt == S_RUN);
			converter_clk_en_r <= (state_nxt == S_RUN) || (state_nxt == S_NOISE);
			osc_enable_r       <= (state_nxt != S_DOWN);
		end
	end

	// Avalon slave: one wait cycle, then answer
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (req && avs_waitrequest) begin
				case (avs_address)
				`OFS_STATUS: avs_readdata <= {24'h000000, cnt_busy, boot_r, state_r};
				`OFS_CONFIG: avs_readdata <= {9'h000, swing_r, sut_r, src_r, 2'h0,
					load_caps_on_r, amp_full_swing_r, rext_sel_r, wake_sel_r,
					range_code_r, source_kind_r};
				default:     avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // clock_source_startup_select

/* File: tb/clk_startup_asserts.sv */
/*
 * Concurrent checks on the clock source and start-up block ports.
 * Assumes one clock domain, clk_sys, with rst_b active low.
 */
`timescale 1ns/1ps
module clk_startup_asserts (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_b,
	// Bus and wake
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       wake_req,
	// Decoded outputs
	input wire logic [4:0] source_kind_r,
	input wire logic [1:0] range_code_r,
	input wire logic       amp_full_swing_r,
	input wire logic       load_caps_on_r,
	input wire logic       osc_enable_r,
	input wire logic       cpu_reset_hold_r,
	input wire logic       cpu_clk_en_r,
	input wire logic       io_clk_en_r,
	input wire logic       converter_clk_en_r
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Decode and selection holding
	chk_kind_onehot: assert property ($onehot(source_kind_r))
		else $error("source kind not one-hot");
	chk_full_xtal: assert property (amp_full_swing_r |-> source_kind_r == 5'h01)
		else $error("full swing outside crystal mode");
	chk_caps_kind: assert property (load_caps_on_r |-> !source_kind_r[0] && !source_kind_r[3])
		else $error("load caps on for wrong source");
	chk_sel_hold: assert property (!cpu_reset_hold_r |-> $stable(source_kind_r) && $stable(range_code_r))
		else $error("selection changed after start-up");
	// Clock gating and bus answer timing
	chk_hold_gate: assert property (cpu_reset_hold_r |-> !cpu_clk_en_r && !io_clk_en_r)
		else $error("core clock on while held");
	chk_hold_release: assert property ($fell(cpu_reset_hold_r) |-> cpu_clk_en_r && osc_enable_r)
		else $error("core released without clock");
	chk_conv_run: assert property (cpu_clk_en_r |-> io_clk_en_r && converter_clk_en_r)
		else $error("run clocks incomplete");
	chk_osc_down: assert property (!osc_enable_r |-> !converter_clk_en_r && !cpu_clk_en_r)
		else $error("clock on with oscillator off");
	chk_wake_slow: assert property ($rose(osc_enable_r) |-> !cpu_clk_en_r [*6])
		else $error("core clock before stabilisation");
	chk_noise_wake: assert property (converter_clk_en_r && !cpu_clk_en_r && wake_req |=> cpu_clk_en_r)
		else $error("noise sleep wake late");
	chk_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");

	// Main scenarios
	cover property (converter_clk_en_r && !cpu_clk_en_r);
	cover property ($rose(osc_enable_r));
	cover property ($fell(cpu_reset_hold_r));
endmodule // clk_startup_asserts

bind clock_source_startup_select clk_startup_asserts u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .wake_req(wake_req), .source_kind_r(source_kind_r),
	.range_code_r(range_code_r), .amp_full_swing_r(amp_full_swing_r), .load_caps_on_r(load_caps_on_r),
	.osc_enable_r(osc_enable_r), .cpu_reset_hold_r(cpu_reset_hold_r), .cpu_clk_en_r(cpu_clk_en_r),
	.io_clk_en_r(io_clk_en_r), .converter_clk_en_r(converter_clk_en_r)
);

/* File: tb/osc_model.sv */
/*
 * Oscillator model: watchdog and selected source cycle ticks.
 * Assumes osc_on comes from the block's oscillator enable.
 */
`timescale 1ns/1ps
module osc_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic osc_on,
	// Ticks
	output logic     src_tick,
	output logic     wdt_tick
);
	logic [1:0] wdt_div_r;

	// Watchdog runs free every third cycle, source stands still when off
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wdt_div_r <= 2'h0;
			wdt_tick <= 1'b0;
			src_tick <= 1'b0;
		end else begin
			wdt_div_r <= (wdt_div_r == 2'h2) ? 2'h0 : wdt_div_r + 2'h1;
			wdt_tick <= (wdt_div_r == 2'h2);
			src_tick <= osc_on & ~src_tick;
		end
	end
endmodule // osc_model

/* File: tb/testbench.sv */
/*
 * Self-checking bench: fuse table loop, then sleep and bus corner cases.
 * Assumes small start-up parameters and the oscillator model.
 */
`timescale 1ns/1ps
module testbench;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        wake_req = 1'b0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [3:0]  src = 4'h1;
	logic [3:0]  avs_address = 4'h0;
	logic [1:0]  sut = 2'h2;
	logic        swing = 1'h1;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] rd;
	logic [22:0] r;
	wire  [31:0] avs_readdata;
	wire  [4:0]  kind;
	wire  [1:0]  range;
	wire         avs_waitrequest, full, caps, osc_on, hold, cpu_en, io_en, conv_en, src_tick, wdt_tick;
	int          failures = 0;
	int          n_checks = 0;
	int          n, lo;
	// Rows: swing, start-up, source fuses, expected decode
	// Range 101 row stands for a resonator fit, never quartz
	logic [22:0] rows [12] = '{23'h610808, 23'h440068, 23'h710808, 23'h102410, 23'h450084, 23'h382464,
		23'h292A82, 23'h790A82, 23'h4A0501, 23'h5D0221, 23'h3F1A61, 23'h6C01A1};

	always #2.5 clk_sys = ~clk_sys;

	clock_source_startup_select #(.WDT_SHORT(17'h00008), .WDT_LONG(17'h00010), .SRC_16K(17'h0000A),
		.SRC_32K(17'h0000C)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .source_select_fuses(src),
		.startup_time_fuses(sut), .swing_option_fuse(swing), .wdt_tick(wdt_tick), .src_tick(src_tick),
		.wake_req(wake_req), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.source_kind_r(kind), .range_code_r(range), .amp_full_swing_r(full), .load_caps_on_r(caps),
		.osc_enable_r(osc_on), .cpu_reset_hold_r(hold), .cpu_clk_en_r(cpu_en), .io_clk_en_r(io_en),
		.converter_clk_en_r(conv_en));

	osc_model u_osc (.clk_sys(clk_sys), .rst_b(rst_b), .osc_on(osc_on), .src_tick(src_tick),
		.wdt_tick(wdt_tick));

	// Wake cycle counts for the parameters above
	function automatic int wc(input logic [2:0] w);
		case (w)
			3'h0: wc = 6;
			3'h1: wc = 18;
			3'h2: wc = 258;
			3'h3: wc = 1024;
			3'h4: wc = 10;
			default: wc = 12;
		endcase
	endfunction

	task final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge clk_sys);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k >= 50) begin
			failures++;
			final_report();
		end
	endtask

	// Bounded wait while hold (sel 0) or the core clock enable (sel 1) keeps a level
	task wait_while(input logic sel, input logic lvl);
		n = 0;
		while ((sel ? cpu_en : hold) === lvl && n < 5000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 5000) begin
			failures++;
			final_report();
		end
	endtask

	initial begin
		for (int i = 0; i < 12; i++) begin
			r = rows[i];
			@(posedge clk_sys);
			src <= r[19:16];
			sut <= r[21:20];
			swing <= r[22];
			rst_b <= 1'b0;
			repeat (4) @(posedge clk_sys);
			rst_b <= 1'b1;
			wait_while(1'b0, 1'b1);
			lo = (r[11:10] == 2'h0 ? 0 : r[11:10] == 2'h1 ? 24 : 48) + wc(r[9:7]) * 2;
			check("boot time", n >= lo - 6 && n <= lo + 10, 1);
			bus(0, 4'h8, 32'h0, rd);
			check("config", rd, {9'h0, r});
			check("pins", {caps, full, range, kind}, {r[13:12], r[6:5], r[4:0]});
			bus(0, 4'h4, 32'h0, rd);
			check("status", rd, 32'h8);
		end
		// Unmapped and write-only places
		bus(1, 4'hC, 32'hFFFFFFFF, rd);
		bus(0, 4'hC, 32'h0, rd);
		check("unmapped", rd, 32'h0);
		bus(0, 4'h0, 32'h0, rd);
		check("ctrl read", rd, 32'h0);
		// Fuse pins move after start-up; the captured image must stay
		src <= 4'h0;
		sut <= 2'h0;
		swing <= 1'b0;
		bus(0, 4'h8, 32'h0, rd);
		check("config kept", rd, {9'h0, r});
		check("pins kept", {caps, full, range, kind}, {r[13:12], r[6:5], r[4:0]});
		// Noise sleep keeps converter clock, wakes at once
		bus(1, 4'h0, 32'h2, rd);
		repeat (2) @(posedge clk_sys);
		check("noise clocks", {cpu_en, io_en, conv_en, osc_on}, 4'h3);
		wake_req <= 1'b1;
		@(posedge clk_sys);
		wake_req <= 1'b0;
		@(posedge clk_sys);
		check("noise wake", cpu_en, 1'b1);
		// Power-down with both bits, then timed wake
		bus(1, 4'h0, 32'h3, rd);
		repeat (20) @(posedge clk_sys);
		check("down clocks", {cpu_en, io_en, conv_en, osc_on}, 4'h0);
		wake_req <= 1'b1;
		@(posedge clk_sys);
		wake_req <= 1'b0;
		wait_while(1'b1, 1'b0);
		lo = wc(r[9:7]) * 2;
		check("wake time", n >= lo - 4 && n <= lo + 8, 1);
		check("after wake", {hold, osc_on}, 2'h1);
		// Reset in mid-run: reset values, then the moved fuse pins are taken
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check("reset outs", {avs_waitrequest, hold, cpu_en, io_en, conv_en, osc_on}, 6'h31);
		check("reset decode", {caps, full, range, kind}, 9'h008);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check("fuses retaken", {hold, caps, full, range, kind}, 10'h310);
		wait_while(1'b0, 1'b1);
		lo = wc(3'h0) * 2;
		check("short boot", n >= lo - 6 && n <= lo + 10, 1);
		bus(0, 4'h8, 32'h0, rd);
		check("new config", rd, 32'h00002010);
		final_report();
	end
endmodule // testbench
